// ==== hw/flash_erase_sequencer.sv ====
// Flash erase command sequencer with status and protection readback.
// Assumes one-cycle bus strobes synchronous to i_ref_clk and
// one-hot sector selects from the address decoder.
//
// Notes on behaviour
// [RULE1] Bulk erase needs six coded writes
// [RULE2] Wrong bulk byte returns to array read
// [RULE3] Error bit reads 1 after failed erase
// [RULE4] Engine preprograms zeros before erasing
// [RULE5] Bulk erase ignores all further writes; the code still accepts reset once the bulk erase has failed
// [RULE6] Sector erase: six writes, last gives sector
// [RULE7] Unprefixed confirms append sectors, restart window
// [RULE8] Expired bit 0 in window, 1 erasing
// [RULE9] Other writes in window abort erase
// [RULE10] Sector erase accepts only reset, suspend
// [RULE11] Suspend code honoured only in sector erase
// [RULE12] Suspend in window also ends window
// [RULE13] Toggle stops within latency, then array read
// [RULE14] Suspended: other sectors read valid data
// [RULE15] Suspended: only resume and reset accepted
// [RULE16] Resume code continues suspended erase
// [RULE17] Protected sectors never programmed or erased
// [RULE18] Protection bits readable, never bus writable
// [RULE19] Reset as one write or three
// [RULE20] Main protect bit i guards sector i
// [RULE21] Second register: sectors, unused, security bit
// [RULE22] Toggle flips on every status read
// [RULE23] Polling bit reads 0 while erasing
// [RULE24] Write without sector select is ignored
`default_nettype none
module flash_erase_sequencer
  import flash_erase_pkg::*;
#(
  parameter int WINDOW_CYCLES  = WINDOW_CYCLES_DEF,
  parameter int PREPROG_CYCLES = PREPROG_CYCLES_DEF,
  parameter int PULSE_CYCLES   = PULSE_CYCLES_DEF,
  parameter int MAX_TRIES      = MAX_TRIES_DEF
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_rd,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_flash_sector_select,
  input  wire logic        i_config_register_space,
  input  wire logic [7:0]  i_array_rdata,
  input  wire logic        i_erase_verified,
  input  wire logic [7:0]  i_main_protect,
  input  wire logic [3:0]  i_second_protect,
  input  wire logic        i_security_bit,
  output logic [7:0]       o_rdata,
  output logic             o_rdata_valid,
  output logic             o_array_program_zero,
  output logic             o_array_erase,
  output logic [7:0]       o_erase_sector_mask,
  output logic             o_busy,
  output logic             o_suspended
);
  state_type   state;
  state_type   next_state;
  logic [2:0]  seq_step;
  logic [2:0]  next_seq_step;
  logic [7:0]  next_mask;
  logic        bulk;
  logic        next_bulk;
  logic        erase_error;
  logic        toggle;
  logic [7:0]  susp_count;
  logic        wr_sel;
  logic        seq_bad;
  logic        timer_restart;
  logic        timer_expired;
  logic        eng_start;
  logic        eng_abort;
  logic        eng_busy;
  logic        eng_done;
  logic        eng_fail;
  logic        status_mode;
  logic        status_hit;

  // Expected address and data of coded step n
  function automatic logic step_ok(input logic [2:0] n, input logic [11:0] a,
                                   input logic [7:0] d);
    case (n)
      3'h0, 3'h3: step_ok = (a == ADDR_UNLOCK1) && (d == CMD_UNLOCK1);
      3'h1, 3'h4: step_ok = (a == ADDR_UNLOCK2) && (d == CMD_UNLOCK2);
      3'h2:       step_ok = (a == ADDR_UNLOCK1) && (d == CMD_ERASE);
      default:    step_ok = 1'b0;
    endcase
  endfunction : step_ok

  assign wr_sel = i_bus_wr && (|i_flash_sector_select); // RULE24

  ////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb begin
    next_state    = state;
    next_seq_step = seq_step;
    next_mask     = o_erase_sector_mask;
    next_bulk     = bulk;
    seq_bad       = 1'b0;
    timer_restart = 1'b0;
    eng_start     = 1'b0;
    eng_abort     = 1'b0;
    case (state)
      ST_READ, ST_SEQ: begin
        if (wr_sel) begin
          if (i_wdata == CMD_RESET) begin
            next_state    = ST_READ; // RULE19
            next_seq_step = 3'h0;
          end else if (seq_step == LAST_STEP) begin
            next_seq_step = 3'h0;
            next_state    = ST_READ;
            if (i_addr[11:0] == ADDR_UNLOCK1 && i_wdata == CMD_BULK) begin
              next_mask = ~i_main_protect; // RULE17
              next_bulk = 1'b1;
              if (|(~i_main_protect)) begin
                next_state = ST_ERASE; // RULE1
                eng_start  = 1'b1;
              end
            end else if (i_wdata == CMD_SECTOR) begin
              next_mask = i_flash_sector_select & ~i_main_protect; // RULE6 RULE17
              next_bulk = 1'b0;
              if (|next_mask) begin
                next_state    = ST_WINDOW;
                timer_restart = 1'b1;
              end
            end else begin
              seq_bad = 1'b1; // RULE2
            end
          end else if (step_ok(seq_step, i_addr[11:0], i_wdata)) begin
            next_seq_step = seq_step + 3'h1;
            next_state    = ST_SEQ;
          end else begin
            seq_bad       = 1'b1;
            next_seq_step = 3'h0;
            next_state    = ST_READ; // RULE2
          end
        end
      end
      ST_WINDOW: begin
        if (wr_sel && i_wdata == CMD_SECTOR) begin
          next_mask     = o_erase_sector_mask | (i_flash_sector_select & ~i_main_protect); // RULE7
          timer_restart = 1'b1; // RULE7
        end else if (wr_sel && i_wdata == CMD_SUSPEND) begin
          next_state = ST_SUSP_WAIT; // RULE12
        end else if (wr_sel) begin
          next_state = ST_READ; // RULE9
          next_mask  = 8'h00;
        end else if (timer_expired) begin
          next_state = ST_ERASE;
          eng_start  = 1'b1;
        end
      end
      ST_ERASE: begin
        if (eng_done) begin
          next_state = ST_READ;
          next_mask  = 8'h00;
        end else if (eng_fail) begin
          next_state = ST_ERASE;
        end else if (wr_sel && !bulk && i_wdata == CMD_RESET && !erase_error) begin
          next_state = ST_READ; // RULE10
          next_mask  = 8'h00;
          eng_abort  = 1'b1;
        end else if (wr_sel && !bulk && i_wdata == CMD_SUSPEND && !erase_error) begin
          next_state = ST_SUSP_WAIT; // RULE11
        end else if (wr_sel && erase_error && i_wdata == CMD_RESET) begin
          next_state = ST_READ;
          next_mask  = 8'h00;
        end
      end
      ST_SUSP_WAIT: begin
        if (eng_done) begin
          next_state = ST_READ;
          next_mask  = 8'h00;
        end else if (susp_count == 8'(SUSP_CYCLES - 1)) begin
          next_state = ST_SUSPEND; // RULE13
        end
      end
      ST_SUSPEND: begin
        if (wr_sel && i_wdata == CMD_RESUME) begin
          next_state = ST_ERASE; // RULE16
          eng_start  = !eng_busy;
        end else if (wr_sel && i_wdata == CMD_RESET) begin
          next_state = ST_READ; // RULE15
          next_mask  = 8'h00;
          eng_abort  = 1'b1;
        end
      end
      default: begin
        next_state    = ST_READ;
        next_seq_step = 3'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Control state
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state               <= ST_READ;
      seq_step            <= 3'h0;
      o_erase_sector_mask <= 8'h00;
      bulk                <= 1'b0;
    end else begin
      state               <= next_state;
      seq_step            <= next_seq_step;
      o_erase_sector_mask <= next_mask;
      bulk                <= next_bulk; // RULE5
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || state != ST_SUSP_WAIT) begin
      susp_count <= 8'h00;
    end else begin
      susp_count <= susp_count + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      erase_error <= 1'b0;
    end else if (eng_fail) begin
      erase_error <= 1'b1; // RULE3
    end else if (state == ST_READ) begin
      erase_error <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path
  assign status_mode = (state == ST_WINDOW) || (state == ST_ERASE) || (state == ST_SUSP_WAIT);
  assign status_hit  = i_bus_rd && !i_config_register_space && status_mode
                       && (|(i_flash_sector_select & o_erase_sector_mask));

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      toggle <= 1'b0;
    end else if (status_hit) begin
      toggle <= ~toggle; // RULE22 RULE13
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= i_bus_rd;
      if (i_bus_rd && i_config_register_space) begin
        if (i_addr[7:0] == OFS_MAIN_PROTECT) begin
          o_rdata <= i_main_protect; // RULE18 RULE20
        end else if (i_addr[7:0] == OFS_SECOND_PROTECT) begin
          o_rdata <= {i_security_bit, 3'h0, i_second_protect}; // RULE21
        end else begin
          o_rdata <= 8'h00;
        end
      end else if (status_hit) begin
        o_rdata              <= 8'h00;
        o_rdata[BIT_POLL]    <= 1'b0; // RULE23
        o_rdata[BIT_TOGGLE]  <= toggle;
        o_rdata[BIT_ERROR]   <= erase_error;
        o_rdata[BIT_EXPIRED] <= (state != ST_WINDOW); // RULE8
      end else if (i_bus_rd) begin
        o_rdata <= i_array_rdata; // RULE14 RULE17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Window timer and erase engine
  flash_append_timer #(
    .WINDOW_CYCLES (WINDOW_CYCLES)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_restart (timer_restart),
    .i_run     (state == ST_WINDOW),
    .o_expired (timer_expired)
  );

  flash_erase_engine #(
    .PREPROG_CYCLES (PREPROG_CYCLES),
    .PULSE_CYCLES   (PULSE_CYCLES),
    .MAX_TRIES      (MAX_TRIES)
  ) u_engine (
    .i_ref_clk        (i_ref_clk),
    .i_sys_rst        (i_sys_rst),
    .i_start          (eng_start), // RULE4
    .i_hold           (state == ST_SUSPEND),
    .i_abort          (eng_abort),
    .i_erase_verified (i_erase_verified),
    .o_busy           (eng_busy),
    .o_done           (eng_done),
    .o_fail           (eng_fail),
    .o_program_zero   (o_array_program_zero),
    .o_erase          (o_array_erase)
  );

  assign o_busy      = status_mode;
  assign o_suspended = (state == ST_SUSPEND);

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_status_rd;
    status_hit;
  endsequence
  sequence s_suspend_cmd;
    (state == ST_WINDOW || (state == ST_ERASE && !bulk && !erase_error && !eng_done
      && !eng_fail)) && wr_sel && i_wdata == CMD_SUSPEND;
  endsequence

  AST_BAD_BYTE_ABORTS: assert property ( // RULE2
    seq_bad |=> state == ST_READ && seq_step == 3'h0)
    else $error("bad coded byte did not abort");
  AST_ERROR_BIT: assert property ( // RULE3
    s_status_rd ##0 erase_error |=> o_rdata[BIT_ERROR])
    else $error("error bit not set after failed erase");
  AST_BULK_IGNORES: assert property ( // RULE5
    state == ST_ERASE && bulk && !eng_done |=> state == ST_ERASE)
    else $error("bulk erase accepted a command");
  AST_EXPIRED_BIT: assert property ( // RULE8
    s_status_rd |=> o_rdata[BIT_EXPIRED] == ($past(state) != ST_WINDOW))
    else $error("expired bit wrong");
  AST_WINDOW_ABORT: assert property ( // RULE9
    state == ST_WINDOW && wr_sel && i_wdata != CMD_SECTOR && i_wdata != CMD_SUSPEND
    |=> state == ST_READ && o_erase_sector_mask == 8'h00)
    else $error("window not aborted");
  AST_SUSPEND_LATENCY: assert property ( // RULE13
    s_suspend_cmd |=> state == ST_SUSP_WAIT ##[12:14] (state == ST_SUSPEND || state == ST_READ))
    else $error("suspend latency wrong");
  AST_SUSPEND_REFUSES: assert property ( // RULE15
    state == ST_SUSPEND && !(wr_sel && (i_wdata == CMD_RESUME || i_wdata == CMD_RESET))
    |=> state == ST_SUSPEND && !o_array_erase && !o_array_program_zero)
    else $error("suspended state left without resume or reset");
  AST_PROTECTED_MASKED: assert property ( // RULE17
    $changed(o_erase_sector_mask)
    |-> (o_erase_sector_mask & ~$past(o_erase_sector_mask) & $past(i_main_protect)) == 8'h00)
    else $error("protected sector queued for erase");
  AST_MAIN_PROT_READ: assert property ( // RULE20
    i_bus_rd && i_config_register_space && i_addr[7:0] == OFS_MAIN_PROTECT
    |=> o_rdata_valid && o_rdata == $past(i_main_protect))
    else $error("main protect register misread");
  AST_TOGGLES: assert property ( // RULE22
    s_status_rd |=> o_rdata[BIT_TOGGLE] != toggle)
    else $error("toggle bit did not change");
  AST_POLL_LOW: assert property ( // RULE23
    s_status_rd |=> !o_rdata[BIT_POLL])
    else $error("polling bit not zero");
  AST_NO_SELECT: assert property ( // RULE24
    (state == ST_READ || state == ST_SEQ) && i_bus_wr && !(|i_flash_sector_select)
    |=> $stable(state) && $stable(seq_step))
    else $error("unselected write changed sequence");
endmodule : flash_erase_sequencer
`default_nettype wire

// ==== hw/flash_erase_pkg.sv ====
// Constants, encodings and timing for the flash erase sequencer.
// Assumes a 125 MHz reference clock.
`default_nettype none
package flash_erase_pkg;
  // Clock and timing
  localparam int CLK_KHZ            = 125000;
  localparam int WINDOW_US          = 100;
  localparam int WINDOW_CYCLES_DEF  = WINDOW_US * CLK_KHZ / 1000;
  localparam int SUSP_MIN_NS        = 100;
  localparam int SUSP_MAX_NS        = 15000;
  localparam int SUSP_CYCLES        = (SUSP_MIN_NS * CLK_KHZ + 999999) / 1000000;
  localparam int SUSP_MAX_CYCLES    = SUSP_MAX_NS * CLK_KHZ / 1000000;
  localparam int PREPROG_CYCLES_DEF = 16;
  localparam int PULSE_CYCLES_DEF   = 32;
  localparam int MAX_TRIES_DEF      = 8;
  // Command bytes and unlock addresses
  localparam logic [7:0]  CMD_UNLOCK1  = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_BULK     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam logic [2:0]  LAST_STEP    = 3'h5;
  // Status byte bit positions
  localparam int BIT_POLL    = 7;
  localparam int BIT_TOGGLE  = 6;
  localparam int BIT_ERROR   = 5;
  localparam int BIT_EXPIRED = 3;
  // Protection registers in configuration space
  localparam logic [7:0] OFS_MAIN_PROTECT   = 8'hC0;
  localparam logic [7:0] OFS_SECOND_PROTECT = 8'hC2;
  localparam int         SECURITY_BIT       = 7;
  // Controller states
  typedef enum logic [5:0] {
    ST_READ      = 6'h01,
    ST_SEQ       = 6'h02,
    ST_WINDOW    = 6'h04,
    ST_ERASE     = 6'h08,
    ST_SUSP_WAIT = 6'h10,
    ST_SUSPEND   = 6'h20
  } state_type;
  // Erase engine phases
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h1,
    PH_PROG  = 3'h2,
    PH_ERASE = 3'h4
  } phase_type;
endpackage : flash_erase_pkg
`default_nettype wire

// ==== hw/flash_append_timer.sv ====
// Sector append window timer.
// Assumes restart and run come from the command controller.
`default_nettype none
module flash_append_timer
  import flash_erase_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYCLES_DEF
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_restart,
  input  wire logic i_run,
  output logic      o_expired
);
  localparam int CW = $clog2(WINDOW_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(WINDOW_CYCLES - 1);

  logic [CW-1:0] count;

  ////////////////////////////////////////////////////////////////////
  // Window count, restarted by each append
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_restart || !i_run) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + CW'(1);
    end
  end

  assign o_expired = i_run && !i_restart && (count == LAST);
endmodule : flash_append_timer
`default_nettype wire

// ==== hw/flash_erase_engine.sv ====
// Embedded erase algorithm: program to zero, then erase pulses.
// Assumes the array reports i_erase_verified after each pulse.
`default_nettype none
module flash_erase_engine
  import flash_erase_pkg::*;
#(
  parameter int PREPROG_CYCLES = PREPROG_CYCLES_DEF,
  parameter int PULSE_CYCLES   = PULSE_CYCLES_DEF,
  parameter int MAX_TRIES      = MAX_TRIES_DEF
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_start,
  input  wire logic i_hold,
  input  wire logic i_abort,
  input  wire logic i_erase_verified,
  output logic      o_busy,
  output logic      o_done,
  output logic      o_fail,
  output logic      o_program_zero,
  output logic      o_erase
);
  phase_type   phase;
  logic [15:0] count;
  logic [7:0]  tries;
  logic        pulse_end;

  assign pulse_end = (phase == PH_ERASE) && !i_hold && (count == 16'(PULSE_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////
  // Phase sequencing
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_abort) begin
      phase <= PH_IDLE;
      count <= 16'h0000;
      tries <= 8'h00;
    end else if (i_start && phase == PH_IDLE) begin
      phase <= PH_PROG;
      count <= 16'h0000;
      tries <= 8'h00;
    end else if (!i_hold) begin
      case (phase)
        PH_PROG: begin
          if (count == 16'(PREPROG_CYCLES - 1)) begin
            phase <= PH_ERASE;
            count <= 16'h0000;
          end else begin
            count <= count + 16'h0001;
          end
        end
        PH_ERASE: begin
          if (pulse_end) begin
            count <= 16'h0000;
            tries <= tries + 8'h01;
            if (i_erase_verified || tries == 8'(MAX_TRIES - 1)) begin
              phase <= PH_IDLE;
            end
          end else begin
            count <= count + 16'h0001;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Completion pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_abort) begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      o_done <= pulse_end && i_erase_verified;
      o_fail <= pulse_end && !i_erase_verified && tries == 8'(MAX_TRIES - 1);
    end
  end

  assign o_busy         = (phase != PH_IDLE);
  assign o_program_zero = (phase == PH_PROG) && !i_hold;
  assign o_erase        = (phase == PH_ERASE) && !i_hold;
endmodule : flash_erase_engine
`default_nettype wire

// ==== verification/flash_array_model.sv ====
// Array stand-in: read data and erase verify result.
// Assumes the bench picks pass or fail for each scenario.
`default_nettype none
module flash_array_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_pass,
  input  wire logic        i_erase,
  input  wire logic [15:0] i_addr,
  output logic [7:0]       o_rdata,
  output logic             o_verified
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data pattern tied to the address
  assign o_rdata = ~i_addr[7:0];
  // Verify passes only after a real erase pulse
  always_ff @(posedge i_ref_clk) begin
    o_verified <= i_pass & i_erase;
  end
endmodule : flash_array_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the flash erase sequencer.
// Assumes shortened window and engine counts.
`default_nettype none
module tb_top
  import flash_erase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [7:0] e;} row_type;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  sel = 8'h00;
  logic        cfg = 1'b0;
  logic        pass = 1'b0;
  logic [7:0]  prot = 8'h80;
  logic [3:0]  prot2 = 4'h5;
  logic        secb = 1'b1;
  logic [7:0]  arr, rdata, mask, d, d2;
  logic        ver, rvalid, prog0, ers, busy, susp;
  int          err_count = 0;
  int          comparisons = 0;
  row_type     rows [3] = '{'{8'hC0, 8'h80}, '{8'hC2, 8'h85}, '{8'hC4, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end
  flash_erase_sequencer #(.WINDOW_CYCLES(20), .PREPROG_CYCLES(2), .PULSE_CYCLES(4),
    .MAX_TRIES(2)) DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_bus_wr(wr_s), .i_bus_rd(rd_s),
    .i_addr(addr), .i_wdata(wdata), .i_flash_sector_select(sel),
    .i_config_register_space(cfg), .i_array_rdata(arr), .i_erase_verified(ver),
    .i_main_protect(prot), .i_second_protect(prot2), .i_security_bit(secb),
    .o_rdata(rdata), .o_rdata_valid(rvalid), .o_array_program_zero(prog0),
    .o_array_erase(ers), .o_erase_sector_mask(mask), .o_busy(busy), .o_suspended(susp));
  flash_array_model model (.i_ref_clk(clk), .i_pass(pass), .i_erase(ers), .i_addr(addr),
    .o_rdata(arr), .o_verified(ver));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [7:0] s);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    sel <= s;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] s, input logic c,
                    output logic [7:0] v);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    sel <= s;
    cfg <= c;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
    chk({7'h0, rvalid}, 8'h01);
  endtask : rd
  task automatic pre(input logic [7:0] s);
    wr({4'h0, ADDR_UNLOCK1}, CMD_UNLOCK1, s);
    wr({4'h0, ADDR_UNLOCK2}, CMD_UNLOCK2, s);
    wr({4'h0, ADDR_UNLOCK1}, CMD_ERASE, s);
    wr({4'h0, ADDR_UNLOCK1}, CMD_UNLOCK1, s);
    wr({4'h0, ADDR_UNLOCK2}, CMD_UNLOCK2, s);
  endtask : pre
  task automatic wait_sig(input logic v, input bit use_prog);
    int n;
    n = 0;
    while (((use_prog ? prog0 : busy) !== v) && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      err_count++;
      $display("BAD %0t wait timed out", $time);
    end
  endtask : wait_sig
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({mask[6:0], busy}, 8'h00);
    wr(16'h00C0, 8'h00, 8'h00);
    // Protection registers read through config space
    for (int i = 0; i < 3; i++) begin
      rd({8'h00, rows[i].a}, 8'h00, 1'b1, d);
      chk(d, rows[i].e);
    end
    // Protection inputs changed under the host
    @(posedge clk);
    prot <= 8'h3C;
    prot2 <= 4'hA;
    secb <= 1'b0;
    rd(16'h00C0, 8'h00, 1'b1, d);
    chk(d, 8'h3C);
    rd(16'h00C2, 8'h00, 1'b1, d);
    chk(d, 8'h0A);
    @(posedge clk);
    prot <= 8'h80;
    prot2 <= 4'h5;
    secb <= 1'b1;
    // No select, protected sector, bad bulk byte
    pre(8'h00);
    wr(16'h0010, CMD_SECTOR, 8'h00);
    chk({7'h0, busy}, 8'h00);
    pre(8'h80);
    wr(16'h7010, CMD_SECTOR, 8'h80);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, busy}, 8'h00);
    pre(8'h01);
    wr({4'h0, ADDR_UNLOCK1}, 8'h11, 8'h01);
    chk({7'h0, busy}, 8'h00);
    wr(16'h0000, CMD_SUSPEND, 8'h01);
    repeat (16) @(posedge clk);
    #1;
    chk({7'h0, susp}, 8'h00);
    // Sector erase with append, failing verify
    pre(8'h01);
    wr(16'h0010, CMD_SECTOR, 8'h01);
    wait_sig(1'b1, 1'b0);
    rd(16'h0010, 8'h01, 1'b0, d);
    chk(d & 8'h88, 8'h00);
    wr(16'h1010, CMD_SECTOR, 8'h02);
    @(posedge clk);
    #1;
    chk(mask, 8'h03);
    wait_sig(1'b1, 1'b1);
    chk({7'h0, prog0}, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h0, prog0, ers}, 8'h01);
    repeat (60) @(posedge clk);
    rd(16'h0010, 8'h01, 1'b0, d);
    rd(16'h0010, 8'h01, 1'b0, d2);
    chk(d & 8'hA8, 8'h28);
    chk({7'h0, d[6] ^ d2[6]}, 8'h01);
    wr(16'h0000, CMD_ERASE, 8'h01);
    chk({7'h0, busy}, 8'h01);
    wr(16'h0000, CMD_RESET, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, busy}, 8'h00);
    // Suspend inside the window, then resume
    pre(8'h01);
    wr(16'h0010, CMD_SECTOR, 8'h01);
    wr(16'h0000, CMD_SUSPEND, 8'h01);
    repeat (16) @(posedge clk);
    #1;
    chk({7'h0, susp}, 8'h01);
    rd(16'h1012, 8'h02, 1'b0, d);
    chk(d, 8'hED);
    wr(16'h0000, CMD_ERASE, 8'h01);
    chk({7'h0, susp}, 8'h01);
    wr(16'h0000, CMD_RESUME, 8'h01);
    @(posedge clk);
    #1;
    chk({6'h0, busy, susp}, 8'h02);
    wr(16'h1010, CMD_SECTOR, 8'h02);
    @(posedge clk);
    #1;
    chk(mask, 8'h01);
    wr({4'h0, ADDR_UNLOCK1}, CMD_UNLOCK1, 8'h01);
    wr({4'h0, ADDR_UNLOCK2}, CMD_UNLOCK2, 8'h01);
    wr(16'h0000, CMD_RESET, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, busy}, 8'h00);
    // Bulk erase ignores writes until it completes
    pass <= 1'b1;
    pre(8'h01);
    wr({4'h0, ADDR_UNLOCK1}, CMD_BULK, 8'h01);
    wait_sig(1'b1, 1'b0);
    chk({7'h0, busy}, 8'h01);
    wr(16'h0000, CMD_RESET, 8'h01);
    chk({7'h0, busy}, 8'h01);
    wait_sig(1'b0, 1'b0);
    chk({7'h0, busy}, 8'h00);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
